/* File: logic/adc_conversion_sequencer.sv */
// holds: apb control, timing and result logic of the 10-bit sar converter
// assumes: inputs synchronous to pclk, comparator answer valid per step
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_sequencer
	import adc_seq_pkg::*;
(
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// system
	input  wire logic        sleep_mode,
	input  wire logic        rc_clk_tick,
	input  wire logic [12:0] trigger_sources,
	// analog side
	input  wire logic        comparator_high,
	output logic      [9:0]  dac_trial,
	output logic             sample_hold_on,
	output logic             analog_power,
	output analog_sel_s      analog_sel,
	// processor
	output logic             wake_request
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic        on_reg, go_reg, done_reg, irq_en_reg, justify_reg;
	logic [4:0]  chan_reg;
	logic [2:0]  clksel_reg;
	logic [1:0]  pref_reg;
	logic        nref_reg;
	logic [3:0]  trig_reg;
	logic [7:0]  res_hi_reg, res_lo_reg;
	logic [9:0]  sar_reg;
	logic [3:0]  bit_idx_reg;
	logic [4:0]  half_cnt_reg;
	logic [5:0]  div_cnt_reg;
	logic [2:0]  delay_reg;
	logic        pd_reg;
	logic [12:0] trig_prev_reg;
	seq_state_e  state_reg;

	logic wr, rd, is_rc, tick, trig_rise, go_wr1, go_wr0;
	logic finish, abort_sw, abort_sleep, kick;
	logic [5:0] div_top;
	logic [9:0] part_val;

	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign is_rc = (clksel_reg[1:0] == rc_code_low);
	assign go_wr1 = wr && paddr == ctrl_a_off && pwdata[go_bit];
	assign go_wr0 = wr && paddr == ctrl_a_off && !pwdata[go_bit];

	// ----------------------------------------
	// conversion clock select
	// ----------------------------------------
	always_comb begin
		case (clksel_reg)
		3'b000:  div_top = 6'd0;
		3'b100:  div_top = 6'd1;
		3'b001:  div_top = 6'd3;
		3'b101:  div_top = 6'd7;
		3'b010:  div_top = 6'd15;
		3'b110:  div_top = 6'd31;
		default: div_top = 6'd0;
		endcase
	end
	// half bit-period tick: sysclk/(top+1) per half is sysclk/n per period, n = 2*(top+1)
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			div_cnt_reg <= 6'd0;
		else if (state_reg != st_conv || div_cnt_reg == div_top)
			div_cnt_reg <= 6'd0;
		else
			div_cnt_reg <= div_cnt_reg + 6'd1;
	end
	// sysclk ticks stop in sleep, rc ticks keep running
	assign tick = is_rc ? rc_clk_tick
		: (!sleep_mode && div_cnt_reg == div_top);

	// ----------------------------------------
	// trigger edge detect
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			trig_prev_reg <= 13'h0000;
		else
			trig_prev_reg <= trigger_sources;
	end
	always_comb begin
		trig_rise = 1'b0;
		if (trig_reg != trig_none && trig_reg <= trig_last)
			trig_rise = trigger_sources[trig_reg - 4'd1]
				&& !trig_prev_reg[trig_reg - 4'd1];
	end

	assign kick = on_reg && !go_reg && (go_wr1 || trig_rise);
	assign finish = state_reg == st_conv && tick
		&& half_cnt_reg == conv_half_periods - 5'd1;
	assign abort_sw = go_reg && go_wr0 && state_reg != st_idle;
	assign abort_sleep = state_reg != st_idle && sleep_mode && !is_rc;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg    <= st_idle;
			half_cnt_reg <= 5'd0;
			delay_reg    <= 3'd0;
		end else if (abort_sw || abort_sleep || !on_reg) begin
			state_reg <= st_idle;
		end else begin
			case (state_reg)
			st_idle: begin
				half_cnt_reg <= 5'd0;
				delay_reg    <= 3'd0;
				if (kick)
					state_reg <= is_rc ? st_delay : st_conv;
			end
			st_delay: begin
				delay_reg <= delay_reg + 3'd1;
				if (delay_reg == rc_start_delay - 3'd1)
					state_reg <= st_conv;
			end
			st_conv: begin
				if (tick)
					half_cnt_reg <= half_cnt_reg + 5'd1;
				if (finish)
					state_reg <= st_idle;
			end
			default: state_reg <= st_idle;
			endcase
		end
	end

	// successive approximation, one bit per two half ticks, msb first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sar_reg     <= sample_reset;
			bit_idx_reg <= 4'd9;
		end else if (state_reg != st_conv) begin
			sar_reg     <= sample_reset;
			bit_idx_reg <= 4'd9;
		end else if (tick && half_cnt_reg[0] && half_cnt_reg >= 5'd3
				&& bit_idx_reg != 4'hf) begin
			sar_reg[bit_idx_reg] <= comparator_high;
			bit_idx_reg <= bit_idx_reg - 4'd1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dac_trial <= sample_reset;
		else begin
			dac_trial <= sar_reg;
			if (state_reg == st_conv && bit_idx_reg != 4'hf)
				dac_trial[bit_idx_reg] <= 1'b1;
		end
	end
	// partial result: unconverted bits copy the last converted one
	always_comb begin
		part_val = sar_reg;
		for (int i = 0; i < result_bits; i++)
			if (bit_idx_reg != 4'hf && i <= 32'(bit_idx_reg))
				part_val[i] = (bit_idx_reg == 4'd9) ? 1'b0
					: sar_reg[bit_idx_reg + 4'd1];
	end

	// ----------------------------------------
	// result bytes
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_hi_reg <= ctrl_reset;
			res_lo_reg <= ctrl_reset;
		end else if (finish || abort_sw) begin
			if (justify_reg) begin
				res_hi_reg <= {6'h00, part_val[9:8]};
				res_lo_reg <= part_val[7:0];
			end else begin
				res_hi_reg <= part_val[9:2];
				res_lo_reg <= {part_val[1:0], 6'h00};
			end
		end else if (wr && paddr == result_high_off) begin
			res_hi_reg <= pwdata[7:0];
		end else if (wr && paddr == result_low_off) begin
			res_lo_reg <= pwdata[7:0];
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			on_reg      <= 1'b0;
			chan_reg    <= 5'd0;
			justify_reg <= 1'b0;
			clksel_reg  <= 3'd0;
			pref_reg    <= 2'd0;
			nref_reg    <= 1'b0;
			trig_reg    <= 4'd0;
			irq_en_reg  <= 1'b0;
		end else if (wr) begin
			case (paddr)
			ctrl_a_off: begin
				on_reg   <= pwdata[on_bit];
				chan_reg <= pwdata[chan_lsb +: 5];
			end
			ctrl_b_off: begin
				justify_reg <= pwdata[justify_bit];
				clksel_reg  <= pwdata[clksel_lsb +: 3];
				nref_reg    <= pwdata[nref_bit];
				if (pwdata[pref_lsb +: 2] != pref_reserved)
					pref_reg <= pwdata[pref_lsb +: 2];
			end
			ctrl_c_off: trig_reg <= pwdata[trig_lsb +: 4];
			irq_en_off: irq_en_reg <= pwdata[irq_en_bit];
			default: ;
			endcase
		end
	end
	// go held for the whole conversion, hardware clear at end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			go_reg <= 1'b0;
		else if (!on_reg || finish || abort_sleep || abort_sw)
			go_reg <= 1'b0;
		else if (kick)
			go_reg <= 1'b1;
	end
	// done flag: set wins over clear, hardware never clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			done_reg <= 1'b0;
		else if (finish)
			done_reg <= 1'b1;
		else if (wr && paddr == flag_off && !pwdata[done_bit])
			done_reg <= 1'b0;
	end
	// power-down in sleep keeps converter_on readable as one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pd_reg <= 1'b0;
		else if (!sleep_mode || !on_reg)
			pd_reg <= 1'b0;
		else if (abort_sleep || (finish && !irq_en_reg))
			pd_reg <= 1'b1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wake_request <= 1'b0;
		else
			wake_request <= finish && sleep_mode && irq_en_reg;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analog_power   <= 1'b0;
			sample_hold_on <= 1'b0;
			analog_sel     <= '0;
		end else begin
			analog_power   <= on_reg && !pd_reg;
			sample_hold_on <= on_reg && state_reg == st_idle;
			analog_sel     <= '{chan_reg, pref_reg, nref_reg};
		end
	end

	// ----------------------------------------
	// apb read
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel && !penable) begin
				case (paddr)
				ctrl_a_off:      prdata[7:0] <= {1'b0, chan_reg, go_reg, on_reg};
				ctrl_b_off:      prdata[7:0] <= {justify_reg, clksel_reg, 1'b0,
					nref_reg, pref_reg};
				ctrl_c_off:      prdata[7:0] <= {trig_reg, 4'h0};
				result_high_off: prdata[7:0] <= res_hi_reg;
				result_low_off:  prdata[7:0] <= res_lo_reg;
				flag_off:        prdata[0]   <= done_reg;
				irq_en_off:      prdata[0]   <= irq_en_reg;
				default:         pslverr     <= 1'b1;
				endcase
			end
		end
	end
	logic unused_rd;
	assign unused_rd = rd;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_done_on_finish: assert property (
		@(posedge pclk) disable iff (!presetn)
		finish |=> done_reg) else $error("done flag not set");
	chk_done_sticky: assert property (
		@(posedge pclk) disable iff (!presetn)
		done_reg && !(wr && paddr == flag_off) |=> done_reg)
		else $error("done flag dropped by hardware");
	chk_go_cleared: assert property (
		@(posedge pclk) disable iff (!presetn)
		finish |=> !go_reg) else $error("go not cleared at end");
	chk_go_held: assert property (
		@(posedge pclk) disable iff (!presetn)
		state_reg == st_conv |-> go_reg) else $error("go low in conv");
	chk_rc_delay: assert property (
		@(posedge pclk) disable iff (!presetn)
		state_reg == st_idle && kick && is_rc && !sleep_mode
		|=> state_reg == st_delay [*4])
		else $error("rc start delay wrong");
	chk_right_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		finish && justify_reg |=> res_hi_reg[7:2] == 6'h00)
		else $error("upper bits not zero");
	chk_left_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		finish && !justify_reg |=> res_lo_reg[5:0] == 6'h00)
		else $error("lower bits not zero");
	chk_wake_req: assert property (
		@(posedge pclk) disable iff (!presetn)
		finish && sleep_mode && irq_en_reg |=> wake_request)
		else $error("no wake request");
	chk_sleep_abort: assert property (
		@(posedge pclk) disable iff (!presetn)
		state_reg == st_conv && sleep_mode && !is_rc |=> !go_reg && on_reg)
		else $error("sleep abort wrong");
	chk_off_idle: assert property (
		@(posedge pclk) disable iff (!presetn)
		!on_reg |=> state_reg == st_idle) else $error("runs while off");
	chk_sleep_pd: assert property (
		@(posedge pclk) disable iff (!presetn)
		finish && sleep_mode && !irq_en_reg |-> ##2 !analog_power)
		else $error("no power-down after sleep finish");
	chk_abort_stop: assert property (
		@(posedge pclk) disable iff (!presetn)
		abort_sw |=> !go_reg && state_reg == st_idle)
		else $error("abort did not stop");
endmodule // adc_conversion_sequencer
`default_nettype wire

/* File: shared/adc_seq_pkg.sv */
// package: constants and types for the conversion sequencer
// assumes: apb slave with 32-bit words, pclk at 25 mhz
package adc_seq_pkg;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [11:0] ctrl_a_off      = 12'h000;
	localparam logic [11:0] ctrl_b_off      = 12'h004;
	localparam logic [11:0] ctrl_c_off      = 12'h008;
	localparam logic [11:0] result_high_off = 12'h00c;
	localparam logic [11:0] result_low_off  = 12'h010;
	localparam logic [11:0] flag_off        = 12'h014;
	localparam logic [11:0] irq_en_off      = 12'h018;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int on_bit      = 0;
	localparam int go_bit      = 1;
	localparam int chan_lsb    = 2;
	localparam int pref_lsb    = 0;
	localparam int nref_bit    = 2;
	localparam int clksel_lsb  = 4;
	localparam int justify_bit = 7;
	localparam int trig_lsb    = 4;
	localparam int done_bit    = 0;
	localparam int irq_en_bit  = 0;
	// ----------------------------------------
	// encodings and counts
	// ----------------------------------------
	localparam logic [3:0] trig_none     = 4'h0;
	localparam logic [3:0] trig_last     = 4'hd;
	localparam logic [1:0] rc_code_low   = 2'h3;
	localparam logic [1:0] pref_reserved = 2'h1;
	localparam int         result_bits   = 10;
	// 11.5 bit periods counted in half periods
	localparam logic [4:0] conv_half_periods = 5'd23;
	// one instruction cycle is four system clocks
	localparam logic [2:0] rc_start_delay = 3'd4;
	localparam logic [7:0] ctrl_reset    = 8'h00;
	localparam logic [9:0] sample_reset  = 10'h000;

	typedef enum logic [1:0] {st_idle, st_delay, st_conv} seq_state_e;

	typedef struct packed {
		logic [4:0] channel;
		logic [1:0] pos_ref;
		logic       neg_ref;
	} analog_sel_s;
endpackage

/* File: test/adc_conversion_sequencer_bench.sv */
// holds: apb driven self-checking bench of the conversion sequencer
// assumes: package and design compiled first, single pclk domain
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_sequencer_bench
	import adc_seq_pkg::*;
;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
	logic        penable = 1'b0, pwrite = 1'b0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, comparator_high, sample_hold_on;
	logic        sleep_mode = 1'b0, rc_clk_tick = 1'b0;
	logic        analog_power, wake_request;
	logic [12:0] trigger_sources = 13'h0000;
	logic [9:0]  dac_trial, target = 10'h2b6;
	analog_sel_s analog_sel;
	int          n_fail = 0, checked = 0, lowcnt = 0, wakes = 0, n0, w0;
	logic [2:0]  codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
	int          halves [6] = '{1, 4, 16, 2, 8, 32};

	// ----------------------------------------
	// design and analog stand-in
	// ----------------------------------------
	assign comparator_high = (dac_trial <= target);
	adc_conversion_sequencer DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
		.rc_clk_tick(rc_clk_tick), .trigger_sources(trigger_sources),
		.comparator_high(comparator_high), .dac_trial(dac_trial),
		.sample_hold_on(sample_hold_on), .analog_power(analog_power),
		.analog_sel(analog_sel), .wake_request(wake_request)
	);

	initial begin
		forever #20 pclk = ~pclk;
	end

	// rc ticks, busy-cycle and wake counters
	always @(posedge pclk) begin
		rc_clk_tick <= ~rc_clk_tick;
		if (sample_hold_on === 1'b0) lowcnt <= lowcnt + 1;
		if (wake_request === 1'b1) wakes <= wakes + 1;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// poll busy until it drops
	task automatic wait_idle;
		for (int i = 0; i < 400; i++) begin
			xfer(1'b0, ctrl_a_off, 32'h0);
			if (rd[go_bit] === 1'b0) break;
		end
	endtask

	task automatic start_sleep(input logic [7:0] b, input logic irq);
		wr(ctrl_b_off, {24'h0, b});
		wr(irq_en_off, {31'h0, irq});
		w0 = wakes;
		wr(ctrl_a_off, 32'h3);
		sleep_mode <= 1'b1;
		repeat (300) @(posedge pclk);
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#(40 * 60000);
		n_fail++;
		report_and_stop;
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 7; k++) rd_chk(12'(k * 4), 32'h0);
		xfer(1'b0, 12'h01c, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("end of test: reset and map");
		wr(ctrl_a_off, 32'h1);
		for (int k = 0; k < 6; k++) begin
			wr(ctrl_b_off, {24'h0, 1'b1, codes[k], 4'h0});
			n0 = lowcnt;
			wr(ctrl_a_off, 32'h3);
			wait_idle;
			n0 = lowcnt - n0;
			chk(32'(n0 >= 23 * halves[k] && n0 <= 24 * halves[k] + 3), 32'h1);
			rd_chk(result_high_off, {30'h0, target[9:8]});
			rd_chk(result_low_off, {24'h0, target[7:0]});
			rd_chk(flag_off, 32'h1);
			wr(flag_off, 32'h1);
			rd_chk(flag_off, 32'h1);
			wr(flag_off, 32'h0);
			rd_chk(flag_off, 32'h0);
		end
		target <= 10'h1c9;
		wr(ctrl_b_off, 32'h0);
		wr(ctrl_a_off, 32'h3);
		wait_idle;
		rd_chk(result_high_off, {24'h0, target[9:2]});
		rd_chk(result_low_off, {24'h0, target[1:0], 6'h0});
		$display("end of test: divisors and formats");
		wr(ctrl_b_off, 32'h60);
		wr(ctrl_a_off, 32'h3);
		wr(ctrl_a_off, 32'h1);
		rd_chk(ctrl_a_off, 32'h1);
		rd_chk(result_high_off, 32'h0);
		rd_chk(result_low_off, 32'h0);
		wr(ctrl_b_off, 32'h00);
		wr(ctrl_a_off, 32'h3);
		repeat (5) @(posedge pclk);
		wr(ctrl_a_off, 32'h1);
		rd_chk(result_high_off, 32'h7f);
		rd_chk(result_low_off, 32'hc0);
		wr(ctrl_a_off, 32'h55);
		wr(ctrl_b_off, 32'h07);
		repeat (2) @(posedge pclk);
		chk({24'h0, analog_sel}, {24'h0, 5'h15, 2'h3, 1'b1});
		wr(ctrl_b_off, 32'h05);
		repeat (2) @(posedge pclk);
		chk({30'h0, analog_sel.pos_ref}, 32'h3);
		$display("end of test: abort and selects");
		wr(flag_off, 32'h0);
		wr(ctrl_b_off, 32'h80);
		for (int n = 1; n < 16; n++) begin
			wr(ctrl_c_off, {24'h0, 4'(n), 4'h0});
			@(posedge pclk);
			trigger_sources <= (n > 13) ? 13'h1fff : 13'h0001 << (n - 1);
			@(posedge pclk);
			trigger_sources <= 13'h0000;
			repeat (4) @(posedge pclk);
			wait_idle;
			rd_chk(flag_off, {31'h0, n < 14});
			wr(flag_off, 32'h0);
		end
		wr(ctrl_c_off, 32'h0);
		trigger_sources <= 13'h1fff;
		repeat (8) @(posedge pclk);
		rd_chk(ctrl_a_off, 32'h55);
		trigger_sources <= 13'h0000;
		$display("end of test: auto trigger");
		start_sleep(8'hb0, 1'b1);
		chk(32'(wakes - w0), 32'h1);
		sleep_mode <= 1'b0;
		rd_chk(flag_off, 32'h1);
		rd_chk(result_low_off, {24'h0, target[7:0]});
		wr(flag_off, 32'h0);
		start_sleep(8'hb0, 1'b0);
		chk({31'h0, analog_power}, 32'h0);
		chk(32'(wakes - w0), 32'h0);
		rd_chk(ctrl_a_off, 32'h1);
		sleep_mode <= 1'b0;
		wr(ctrl_b_off, 32'he0);
		wr(ctrl_a_off, 32'h3);
		repeat (10) @(posedge pclk);
		sleep_mode <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({31'h0, analog_power}, 32'h0);
		rd_chk(ctrl_a_off, 32'h1);
		sleep_mode <= 1'b0;
		$display("end of test: sleep");
		wr(ctrl_a_off, 32'h3);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk({31'h0, analog_power}, 32'h0);
		rd_chk(ctrl_a_off, 32'h0);
		rd_chk(ctrl_b_off, 32'h0);
		$display("end of test: reset mid conversion");
		report_and_stop;
	end
endmodule // adc_conversion_sequencer_bench
`default_nettype wire
